/* File: logic/chan_arb_pkg.sv */
// Shared constants and types for the channel cycle-steal arbiter
package chan_arb_pkg;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STEAL_NS = 660;
    localparam int STEAL_CYC = (STEAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [6:0] STEAL_LAST = 7'(STEAL_CYC - 1);
    localparam int N_REQ = 3;
    localparam int ADDR_W = 24;
    localparam int CNT_W = 16;
    localparam int SUB_MAX = 64;
    localparam int UCW_BYTES = 16;
    localparam int UCW_BITS = UCW_BYTES * 8;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] STRAP_WAIT = 2'h2;
    localparam logic [6:0] SUB_SMALL = 7'h10;
    localparam logic [6:0] SUB_LARGE = 7'h40;
    // Requester / source codes
    localparam logic [1:0] SRC_ADAPTER = 2'h0;
    localparam logic [1:0] SRC_SEL1 = 2'h1;
    localparam logic [1:0] SRC_SEL2 = 2'h2;
    localparam logic [1:0] SRC_MPX = 2'h3;
    // Channel numbers
    localparam logic [1:0] CHAN_ZERO = 2'h0;
    localparam logic [1:0] CHAN_ONE = 2'h1;
    localparam logic [1:0] CHAN_TWO = 2'h2;
    localparam logic [1:0] CHAN_THREE = 2'h3;
    localparam logic [1:0] BE_BOTH = 2'h3;
    localparam logic [1:0] BE_HIGH = 2'h2;
    localparam logic [1:0] BE_LOW = 2'h1;
    localparam logic [1:0] ONE_BYTE = 2'h1;
    localparam logic [1:0] TWO_BYTES = 2'h2;

    typedef enum logic [0:0] {ARB_IDLE, ARB_BUSY} arb_state_t;
    typedef enum logic [1:0] {OP_NONE, OP_START, OP_HALT, OP_END} op_cmd_t;
endpackage // chan_arb_pkg

/* File: logic/channel_cycle_steal_arbiter.sv */
// Channel numbering, cycle-steal arbitration and byte multiplexer subchannel state
// Notes on behaviour
// - byte multiplexer and line adapter use channel 0
// - disk adapter 1; selectors 1,2 or 2,3
// - each steal holds storage for 660 ns
// - steal updates byte count and storage address
// - microprogram held during steals, resumes untouched
// - multiplexer requests rank below all steals
// - every sampled requester served within three steals
// - sampled order: adapter, selector one, selector two
// - rotate grants until sampled set drained
// - check data parity and control logic
// - multiplexer moves one byte per transfer
// - 16 or 64 subchannels, fixed at install
// - each subchannel owns 16-byte control word
// - active operations never exceed configured subchannels
// - console and each line take one subchannel
// - adapter steals move exactly one byte
// - halt stops only the addressed device
module channel_cycle_steal_arbiter
    import chan_arb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic adapter_present_pin,
    input wire logic sub64_pin,
    input wire logic [N_REQ-1:0] cs_req,
    input wire logic [N_REQ-1:0] cs_write,
    input wire logic [N_REQ-1:0] cs_two,
    input wire logic [N_REQ-1:0][15:0] cs_wdata,
    input wire logic [N_REQ-1:0][1:0] cs_wpar,
    output logic [N_REQ-1:0] cs_grant,
    output logic [N_REQ-1:0][CNT_W-1:0] cs_count,
    output logic [N_REQ-1:0][ADDR_W-1:0] cs_addr,
    input wire logic ld_en,
    input wire logic [1:0] ld_src,
    input wire logic [ADDR_W-1:0] ld_addr,
    input wire logic [CNT_W-1:0] ld_count,
    input wire logic mpx_req,
    input wire logic mpx_write,
    input wire logic [ADDR_W-1:0] mpx_addr,
    input wire logic [7:0] mpx_wdata,
    input wire logic mpx_wpar,
    output logic mpx_grant,
    output logic micro_hold,
    output logic store_start,
    output logic store_we,
    output logic [ADDR_W-1:0] store_addr,
    output logic [15:0] store_wdata,
    output logic [1:0] store_wpar,
    output logic [1:0] store_be,
    input wire logic [15:0] store_rdata,
    input wire logic [1:0] store_rpar,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic [1:0] rd_par,
    output logic [1:0] rd_src,
    input wire logic rd_ready,
    output logic [1:0] mpx_chan,
    output logic [1:0] line_chan,
    output logic [1:0] adapter_chan,
    output logic [1:0] sel1_chan,
    output logic [1:0] sel2_chan,
    output logic [6:0] sub_count,
    input wire op_cmd_t op_cmd,
    input wire logic [5:0] op_idx,
    output logic op_refused,
    output logic [6:0] active_ops,
    input wire logic ucw_we,
    input wire logic [5:0] ucw_idx,
    input wire logic [UCW_BITS-1:0] ucw_wdata,
    output logic [UCW_BITS-1:0] ucw_rdata,
    input wire logic err_clr,
    output logic par_err,
    output logic ctrl_err
);
    typedef struct packed {
        arb_state_t st;
        logic [6:0] win;
        logic [N_REQ-1:0] pend;
        logic [1:0] rot;
        logic [1:0] cur;
        logic [N_REQ-1:0][ADDR_W-1:0] addr;
        logic [N_REQ-1:0][CNT_W-1:0] count;
        logic [N_REQ-1:0] grant;
        logic mpx_grant;
        logic hold;
        logic store_start;
        logic store_we;
        logic [ADDR_W-1:0] store_addr;
        logic [15:0] store_wdata;
        logic [1:0] store_wpar;
        logic [1:0] store_be;
        logic [BUF_DEPTH-1:0][15:0] buf_data;
        logic [BUF_DEPTH-1:0][1:0] buf_par;
        logic [BUF_DEPTH-1:0][1:0] buf_src;
        logic [1:0] buf_cnt;
        logic rd_valid;
        logic [1:0] strap_meta;
        logic [1:0] strap_sync;
        logic [1:0] init_cnt;
        logic adapter_in;
        logic sub64;
        logic [1:0] sel1_chan;
        logic [1:0] sel2_chan;
        logic [6:0] nsub;
        logic [SUB_MAX-1:0] active;
        logic [6:0] act_cnt;
        logic op_refused;
        logic par_err;
        logic ctrl_err;
    } state_t;

    state_t q;
    state_t d;
    logic [UCW_BITS-1:0] ucw_mem [SUB_MAX];
    logic [UCW_BITS-1:0] ucw_rdata_q;
    logic pop;
    logic push;
    logic [1:0] wpos;
    logic [N_REQ-1:0] pend_now;
    logic [1:0] rot_now;
    logic [1:0] pick;
    logic pick_ok;
    logic [1:0] idx;
    logic [1:0] nbytes;
    logic [1:0] be;

    // Odd parity over one byte
    function automatic logic odd_par(input logic [7:0] b);
        odd_par = ~^b;
    endfunction

    always_comb begin
        d = q;
        d.grant = '0;
        d.mpx_grant = 1'b0;
        d.store_start = 1'b0;
        d.op_refused = 1'b0;
        pick = SRC_ADAPTER;
        pick_ok = 1'b0;
        idx = SRC_ADAPTER;
        nbytes = ONE_BYTE;
        be = BE_HIGH;
        push = 1'b0;
        // Straps pass two flops, then freeze once settled
        d.strap_meta = {adapter_present_pin, sub64_pin};
        d.strap_sync = q.strap_meta;
        if (q.init_cnt <= STRAP_WAIT) begin
            d.init_cnt = q.init_cnt + 2'h1;
        end
        // Latch only once the second flop holds the pins
        if (q.init_cnt == STRAP_WAIT) begin
            d.adapter_in = q.strap_sync[1];
            d.sub64 = q.strap_sync[0];
        end
        d.sel1_chan = q.adapter_in ? CHAN_TWO : CHAN_ONE;
        d.sel2_chan = q.adapter_in ? CHAN_THREE : CHAN_TWO;
        d.nsub = q.sub64 ? SUB_LARGE : SUB_SMALL;

        // Output buffer drains head first
        pop = rd_ready && (q.buf_cnt != 2'h0);
        if (pop) begin
            d.buf_data[0] = q.buf_data[1];
            d.buf_par[0] = q.buf_par[1];
            d.buf_src[0] = q.buf_src[1];
            d.buf_cnt = q.buf_cnt - 2'h1;
        end
        wpos = pop ? q.buf_cnt - 2'h1 : q.buf_cnt;

        if (q.pend == '0) begin
            pend_now = cs_req;
            rot_now = SRC_ADAPTER;
        end else begin
            pend_now = q.pend;
            rot_now = q.rot;
        end
        for (int k = N_REQ - 1; k >= 0; k--) begin
            idx = 2'((int'(rot_now) + k) % N_REQ);
            if (pend_now[idx]) begin
                pick = idx;
                pick_ok = 1'b1;
            end
        end

        if (err_clr) begin
            d.par_err = 1'b0;
            d.ctrl_err = 1'b0;
        end

        unique case (q.st)
            ARB_IDLE: begin
                d.pend = pend_now;
                d.rot = rot_now;
                // Read data needs a free slot, so nothing is started into a full buffer
                if (pick_ok && q.buf_cnt != BUF_FULL) begin
                    nbytes = (pick != SRC_ADAPTER && cs_two[pick]) ? TWO_BYTES : ONE_BYTE;
                    if (nbytes == TWO_BYTES) begin
                        be = BE_BOTH;
                    end else begin
                        be = q.addr[pick][0] ? BE_LOW : BE_HIGH;
                    end
                    d.st = ARB_BUSY;
                    d.win = 7'h0;
                    d.cur = pick;
                    // served one leaves set, pointer moves on
                    d.pend[pick] = 1'b0;
                    d.rot = (pick == SRC_SEL2) ? SRC_ADAPTER : pick + 2'h1;
                    d.grant[pick] = 1'b1;
                    d.store_start = 1'b1;
                    d.store_we = cs_write[pick];
                    d.store_addr = q.addr[pick];
                    d.store_wdata = cs_wdata[pick];
                    d.store_wpar = cs_wpar[pick];
                    d.store_be = be;
                    d.addr[pick] = q.addr[pick] + {{(ADDR_W-2){1'b0}}, nbytes};
                    d.count[pick] = q.count[pick] - {{(CNT_W-2){1'b0}}, nbytes};
                    if (cs_write[pick] &&
                        ((be[1] && cs_wpar[pick][1] != odd_par(cs_wdata[pick][15:8])) ||
                         (be[0] && cs_wpar[pick][0] != odd_par(cs_wdata[pick][7:0])))) begin
                        d.par_err = 1'b1;
                    end
                // multiplexer only when no steal pending
                end else if (pend_now == '0 && cs_req == '0 && mpx_req &&
                             q.buf_cnt != BUF_FULL) begin
                    d.st = ARB_BUSY;
                    d.win = 7'h0;
                    d.cur = SRC_MPX;
                    d.mpx_grant = 1'b1;
                    d.store_start = 1'b1;
                    d.store_we = mpx_write;
                    d.store_addr = mpx_addr;
                    d.store_wdata = {mpx_wdata, mpx_wdata};
                    d.store_wpar = {mpx_wpar, mpx_wpar};
                    d.store_be = mpx_addr[0] ? BE_LOW : BE_HIGH;
                    if (mpx_write && mpx_wpar != odd_par(mpx_wdata)) begin
                        d.par_err = 1'b1;
                    end
                end
            end
            ARB_BUSY: begin
                d.win = q.win + 7'h1;
                if (q.win == STEAL_LAST) begin
                    d.st = ARB_IDLE;
                    d.win = 7'h0;
                    push = !q.store_we;
                end
            end
        endcase

        if (push) begin
            d.buf_data[wpos[0]] = store_rdata;
            d.buf_par[wpos[0]] = store_rpar;
            d.buf_src[wpos[0]] = q.cur;
            d.buf_cnt = d.buf_cnt + 2'h1;
            if ((q.store_be[1] && store_rpar[1] != odd_par(store_rdata[15:8])) ||
                (q.store_be[0] && store_rpar[0] != odd_par(store_rdata[7:0]))) begin
                d.par_err = 1'b1;
            end
        end
        d.rd_valid = d.buf_cnt != 2'h0;

        if (q.win > STEAL_LAST || (q.st == ARB_IDLE && q.win != 7'h0) ||
            q.buf_cnt > BUF_FULL || q.act_cnt > q.nsub) begin
            d.ctrl_err = 1'b1;
        end

        // hold across a run of steals
        d.hold = (d.st == ARB_BUSY && d.cur != SRC_MPX) || (d.pend != '0) || (cs_req != '0);

        if (ld_en && ld_src != SRC_MPX) begin
            d.addr[ld_src] = ld_addr;
            d.count[ld_src] = ld_count;
        end

        unique case (op_cmd)
            OP_NONE: begin
            end
            OP_START: begin
                if ({1'b0, op_idx} >= q.nsub || q.active[op_idx] || q.act_cnt >= q.nsub) begin
                    d.op_refused = 1'b1;
                end else begin
                    d.active[op_idx] = 1'b1;
                    d.act_cnt = q.act_cnt + 7'h1;
                end
            end
            OP_HALT, OP_END: begin
                if (q.active[op_idx]) begin
                    d.active[op_idx] = 1'b0;
                    d.act_cnt = q.act_cnt - 7'h1;
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '0;
            q.st <= ARB_IDLE;
            q.nsub <= SUB_SMALL;
            q.sel1_chan <= CHAN_ONE;
            q.sel2_chan <= CHAN_TWO;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ucw_rdata_q <= '0;
        end else begin
            if (ucw_we && {1'b0, ucw_idx} < q.nsub) begin
                ucw_mem[ucw_idx] <= ucw_wdata;
            end
            ucw_rdata_q <= ucw_mem[ucw_idx];
        end
    end

    assign cs_grant = q.grant;
    assign cs_count = q.count;
    assign cs_addr = q.addr;
    assign mpx_grant = q.mpx_grant;
    assign micro_hold = q.hold;
    assign store_start = q.store_start;
    assign store_we = q.store_we;
    assign store_addr = q.store_addr;
    assign store_wdata = q.store_wdata;
    assign store_wpar = q.store_wpar;
    assign store_be = q.store_be;
    assign rd_valid = q.rd_valid;
    assign rd_data = q.buf_data[0];
    assign rd_par = q.buf_par[0];
    assign rd_src = q.buf_src[0];
    // multiplexer and lines on channel 0
    assign mpx_chan = CHAN_ZERO;
    assign line_chan = CHAN_ZERO;
    assign adapter_chan = CHAN_ONE;
    assign sel1_chan = q.sel1_chan;
    assign sel2_chan = q.sel2_chan;
    assign sub_count = q.nsub;
    assign op_refused = q.op_refused;
    assign active_ops = q.act_cnt;
    assign ucw_rdata = ucw_rdata_q;
    assign par_err = q.par_err;
    assign ctrl_err = q.ctrl_err;
endmodule // channel_cycle_steal_arbiter

/* File: verif/chan_arb_sva.sv */
// Port assertions for the cycle-steal arbiter
module chan_arb_sva
    import chan_arb_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [N_REQ-1:0] cs_req,
    input wire logic [N_REQ-1:0] cs_grant,
    input wire logic [N_REQ-1:0][CNT_W-1:0] cs_count,
    input wire logic [N_REQ-1:0][ADDR_W-1:0] cs_addr,
    input wire logic ld_en,
    input wire logic mpx_grant,
    input wire logic micro_hold,
    input wire logic store_start,
    input wire logic [1:0] store_be,
    input wire logic [1:0] mpx_chan,
    input wire logic [1:0] line_chan,
    input wire logic [1:0] adapter_chan,
    input wire logic [1:0] sel1_chan,
    input wire logic [1:0] sel2_chan,
    input wire logic [6:0] sub_count,
    input wire logic [6:0] active_ops
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Cycles since last window start; saturates so long idle spans stay legal
    logic [7:0] gap_q, gap_d;
    always_comb gap_d = store_start ? 8'h1 :
        (gap_q != 8'h0 && gap_q != 8'hff) ? gap_q + 8'h1 : gap_q;
    always_ff @(posedge clk) gap_q <= rst ? 8'h0 : gap_d;
    a_mux_chan_zero: assert property (mpx_chan == 2'h0 && line_chan == 2'h0)
        else $error("multiplexer or line channel not zero");
    a_sel_chan_pair: assert property (adapter_chan == 2'h1 &&
        ({sel1_chan, sel2_chan} == 4'h6 || {sel1_chan, sel2_chan} == 4'hb))
        else $error("channel numbering wrong");
    a_steal_gap: assert property (store_start && gap_q != 8'h0 |->
        gap_q >= 8'(STEAL_CYC + 1))
        else $error("storage windows too close");
    a_count_step: assert property (cs_grant[0] && !$past(ld_en) |->
        cs_count[0] == $past(cs_count[0]) - 16'h1 && cs_addr[0] == $past(cs_addr[0]) + 24'h1)
        else $error("adapter count or address not stepped");
    a_hold_steal: assert property (cs_grant != 3'h0 |-> micro_hold [*8])
        else $error("microprogram not held during steal");
    a_mpx_lowest: assert property (mpx_grant |-> $past(cs_req) == 3'h0)
        else $error("multiplexer served over a steal request");
    a_grant_single: assert property (cs_grant != 3'h0 |->
        $onehot(cs_grant) && store_start)
        else $error("grant not one-hot with window start");
    a_mpx_one_byte: assert property (mpx_grant |->
        store_start && store_be != BE_BOTH && !micro_hold)
        else $error("multiplexer transfer not one byte");
    a_sub_size: assert property (sub_count == SUB_SMALL || sub_count == SUB_LARGE)
        else $error("subchannel count illegal");
    a_ops_bounded: assert property (active_ops <= sub_count)
        else $error("active operations above subchannels");
    a_adapter_byte: assert property (cs_grant[0] |-> store_be != BE_BOTH)
        else $error("adapter steal moved two bytes");
    c_sel2: cover property (cs_grant[2]);
    c_mpx: cover property (mpx_grant);
    c_full: cover property (active_ops == sub_count);
endmodule // chan_arb_sva
bind channel_cycle_steal_arbiter chan_arb_sva chk (.clk, .rst, .cs_req, .cs_grant, .cs_count,
    .cs_addr, .ld_en, .mpx_grant, .micro_hold, .store_start, .store_be, .mpx_chan, .line_chan,
    .adapter_chan, .sel1_chan, .sel2_chan, .sub_count, .active_ops);

/* File: verif/store_model.sv */
// Processor storage model: byte memory, one answer per window
module store_model
    import chan_arb_pkg::*;
(
    input wire logic clk,
    input wire logic store_start,
    input wire logic store_we,
    input wire logic [ADDR_W-1:0] store_addr,
    input wire logic [15:0] store_wdata,
    input wire logic [1:0] store_be,
    output logic [15:0] store_rdata,
    output logic [1:0] store_rpar
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [7:0] a_q = 8'h0;
    logic [15:0] junk_q = 16'h0;
    int w_q = 0;
    initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    always @(posedge clk) begin
        junk_q <= junk_q + 16'h9e37;
        w_q <= store_start ? 1 : (w_q != 0 && w_q < STEAL_CYC - 1) ? w_q + 1 : 0;
        if (store_start) begin
            a_q <= {store_addr[7:1], 1'b0};
            if (store_we && store_be[1]) mem[{store_addr[7:1], 1'b0}] <= store_wdata[15:8];
            if (store_we && store_be[0]) mem[{store_addr[7:1], 1'b1}] <= store_wdata[7:0];
        end
    end
    // Moving pattern outside access time, so stale data cannot pass
    assign store_rdata = w_q >= STEAL_CYC / 2 ? {mem[a_q], mem[a_q | 8'h1]} : junk_q;
    assign store_rpar = {~^store_rdata[15:8], ~^store_rdata[7:0]};
endmodule // store_model

/* File: verif/tb.sv */
// Random steal traffic, straps, subchannel operations
module tb
    import chan_arb_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(n, e, a) begin n_compared++; if ((e) !== (a)) begin mismatches++; \
    $display("Error %s exp %h got %h", n, e, a); end end
    logic clk, rst, adapter_present_pin, sub64_pin, ld_en, mpx_req, mpx_write, mpx_wpar;
    logic rd_ready, ucw_we, err_clr, mpx_grant, micro_hold, store_start, store_we;
    logic rd_valid, op_refused, par_err, ctrl_err, run;
    logic [2:0] cs_req, cs_write, cs_two, cs_grant, pend;
    logic [2:0][15:0] cs_wdata;
    logic [2:0][1:0] cs_wpar;
    logic [2:0][CNT_W-1:0] cs_count;
    logic [2:0][ADDR_W-1:0] cs_addr;
    logic [1:0] ld_src, store_wpar, store_be, store_rpar, rd_par, rd_src, lm;
    logic [1:0] mpx_chan, line_chan, adapter_chan, sel1_chan, sel2_chan;
    logic [ADDR_W-1:0] ld_addr, mpx_addr, store_addr, ma [3];
    logic [CNT_W-1:0] ld_count, mc [3];
    logic [7:0] mpx_wdata, mem [256];
    logic [15:0] store_wdata, store_rdata, rd_data;
    logic [6:0] sub_count, active_ops;
    op_cmd_t op_cmd;
    logic [5:0] op_idx, ucw_idx;
    logic [UCW_BITS-1:0] ucw_wdata, ucw_rdata, uw;
    logic [33:0] rq [$], h;
    int mismatches = 0, n_compared = 0, seed = 32, g, sc, cyc = 0, wl = 0;
    channel_cycle_steal_arbiter DUT (.clk, .rst, .adapter_present_pin, .sub64_pin, .cs_req,
        .cs_write, .cs_two, .cs_wdata, .cs_wpar, .cs_grant, .cs_count, .cs_addr, .ld_en,
        .ld_src, .ld_addr, .ld_count, .mpx_req, .mpx_write, .mpx_addr, .mpx_wdata, .mpx_wpar,
        .mpx_grant, .micro_hold, .store_start, .store_we, .store_addr, .store_wdata,
        .store_wpar, .store_be, .store_rdata, .store_rpar, .rd_valid, .rd_data, .rd_par,
        .rd_src, .rd_ready, .mpx_chan, .line_chan, .adapter_chan, .sel1_chan, .sel2_chan,
        .sub_count, .op_cmd, .op_idx, .op_refused, .active_ops, .ucw_we, .ucw_idx,
        .ucw_wdata, .ucw_rdata, .err_clr, .par_err, .ctrl_err);
    store_model mem_side (.clk, .store_start, .store_we, .store_addr, .store_wdata,
        .store_be, .store_rdata, .store_rpar);
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Model storage effect; reads queue the expected buffer entry
    task automatic serve(input logic [1:0] s, input logic [23:0] a, input logic two,
            input logic we, input logic [15:0] wd);
        logic [15:0] m;
        m = two ? 16'hffff : (a[0] ? 16'h00ff : 16'hff00);
        if (we && m[15]) mem[{a[7:1], 1'b0}] = wd[15:8];
        if (we && m[0]) mem[{a[7:1], 1'b1}] = wd[7:0];
        if (!we) rq.push_back({m, mem[{a[7:1], 1'b0}], mem[{a[7:1], 1'b1}], s});
    endtask
    task automatic op(input op_cmd_t c, input int i, input logic r, input int n);
        op_cmd = c;
        op_idx = 6'(i);
        @(negedge clk);
        `CHK("op_refused", r, op_refused)
        `CHK("active_ops", 7'(n), active_ops)
        op_cmd = OP_NONE;
        @(negedge clk);
    endtask
    always @(negedge clk) begin
        cyc++;
        // Cycles until the arbiter is idle again
        if (wl != 0) wl--;
        if (!rst && cs_grant !== 3'h0) begin
            wl = STEAL_CYC;
            g = pend[0] ? 0 : pend[1] ? 1 : 2;
            `CHK("cs_grant", 3'(1 << g), cs_grant)
            pend[g] = 1'b0;
            serve(2'(g), ma[g], g != 0, cs_write[g], cs_wdata[g]);
            ma[g] += (g == 0) ? 24'h1 : 24'h2;
            mc[g] -= (g == 0) ? 16'h1 : 16'h2;
            `CHK("cs_addr", ma[g], cs_addr[g])
            `CHK("cs_count", mc[g], cs_count[g])
            cs_req[g] = 1'b0;
        end
        if (!rst && mpx_grant === 1'b1) begin
            serve(SRC_MPX, mpx_addr, 1'b0, mpx_write, {2{mpx_wdata}});
            wl = STEAL_CYC;
            mpx_req = 1'b0;
        end
        // Long stall spans fill the buffer and hold off grants
        rd_ready = !cyc[9] && ($random(seed) & 3) != 0;
        if (rd_valid !== 1'b0 && rd_ready) begin
            `CHK("rd_expected", 1'b1, rq.size() != 0)
            h = rq.size() != 0 ? rq.pop_front() : 34'h0;
            `CHK("rd_data", h[17:2] & h[33:18], rd_data & h[33:18])
            `CHK("rd_src", h[1:0], rd_src)
            lm = {h[33], h[18]};
            `CHK("rd_par", {~^h[17:10], ~^h[9:2]} & lm, rd_par & lm)
        end
        for (int i = 0; i < 3; i++)
            if (run && !cs_req[i] && !cs_grant[i] && ($random(seed) & 255) == 0) begin
                cs_req[i] = 1'b1;
                cs_write[i] = 1'($random(seed));
                cs_wdata[i] = 16'($random(seed));
                if (i == 0) cs_wdata[0][7:0] = cs_wdata[0][15:8];
                cs_wpar[i] = {~^cs_wdata[i][15:8], ~^cs_wdata[i][7:0]};
            end
        if (run && !mpx_req && mpx_grant !== 1'b1 && ($random(seed) & 15) == 0) begin
            mpx_req = 1'b1;
            {mpx_write, mpx_wdata, mpx_addr} = 33'($random(seed));
            mpx_wpar = ~^mpx_wdata;
        end
        // Idle with no set left: the next edge samples requests, full buffer or not
        if (!rst && wl == 0 && pend == 3'h0) pend = cs_req;
    end
    initial begin
        {rst, ld_en, mpx_req, rd_ready, ucw_we, err_clr, run} = 7'h40;
        {cs_req, cs_write, cs_wdata, cs_wpar, ld_src, ld_addr, ld_count} = '0;
        {mpx_write, mpx_addr, mpx_wdata, mpx_wpar, op_idx, ucw_idx, ucw_wdata} = '0;
        {adapter_present_pin, sub64_pin, pend, cs_two} = 8'h06;
        op_cmd = OP_NONE;
        for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        for (int cfg = 0; cfg < 2; cfg++) begin
            adapter_present_pin = cfg == 0;
            sub64_pin = cfg == 1;
            sc = cfg ? 64 : 16;
            rst = 1'b1;
            repeat (3) @(negedge clk);
            rst = 1'b0;
            pend = 3'h0;
            wl = 0;
            repeat (6) @(negedge clk);
            `CHK("line_chan", 4'h0, {mpx_chan, line_chan})
            `CHK("sel_chans", cfg ? 6'h16 : 6'h1b, {adapter_chan, sel1_chan, sel2_chan})
            `CHK("sub_count", 7'(sc), sub_count)
            for (int i = 0; i < 3; i++) begin
                {ld_en, ld_src, ld_addr, ld_count} = {1'b1, 2'(i), 24'(i * 64), 16'h100};
                ma[i] = 24'(i * 64);
                mc[i] = 16'h100;
                @(negedge clk);
            end
            ld_en = 1'b0;
            run = 1'b1;
            repeat (6000) @(negedge clk);
            run = 1'b0;
            for (int t = 0; t < 3000 && (cs_req != 3'h0 || mpx_req || rq.size() != 0); t++)
                @(negedge clk);
            `CHK("drained", 1'b0, cs_req != 3'h0 || mpx_req || rq.size() != 0)
            for (int i = 0; i <= 64; i++) op(OP_START, i, i >= sc, i < sc ? i + 1 : sc);
            op(OP_HALT, 3, 1'b0, sc - 1);
            op(OP_END, 7, 1'b0, sc - 2);
            op(OP_START, 3, 1'b0, sc - 1);
            op(OP_START, 0, 1'b1, sc - 1);
            uw = {$random(seed), $random(seed), $random(seed), $random(seed)};
            {ucw_we, ucw_idx, ucw_wdata} = {1'b1, 6'h5, uw};
            @(negedge clk);
            ucw_we = 1'b0;
            @(negedge clk);
            `CHK("ucw_rdata", uw, ucw_rdata)
            `CHK("errors", 2'h0, {par_err, ctrl_err})
        end
        end_sim();
    end
    initial begin
        #(8 * 40000);
        mismatches++;
        end_sim();
    end
endmodule // tb
